//--- wdg_pkg.sv
// wdg_pkg: constants for the watchdog and system option block
// assumes one 100 MHz reference clock that stands for the oscillator clock
// Overview of operation
// R1: rate bit picks 8176 or 262128 cycle timeout
// R2: 6-bit watchdog counter fed by 12-bit prescaler
// R3: unserviced overflow raises a system reset
// R4: service write clears watchdog and prescaler 12..5
// R5: watchdog reset drives pin low 32 cycles, flags
// R6: test voltage in monitor or break disables watchdog
// R7: service read returns reset vector low byte
// R8: stop instruction clears the prescaler
// R9: power-on clears prescaler 4096 cycles after power-up
// R10: any internal reset clears both counters
// R11: short recovery 32 cycles else 4096 on stop exit
// R12: stop exit by reset always uses long recovery
// R13: monitor-in-stop keeps monitor on when powered, reset clears
// R14: reset disable bit blocks low-voltage monitor resets
// R15: power disable bit powers monitor down
// R16: mode bit picks 5-V or 3-V, power-on only
// R17: software services watchdog from main loop
// R18: oscillator clock runs at crystal rate
// R19: watchdog advances on prescaler carry out
package wdg_pkg;
  localparam int unsigned PRE_W      = 12;
  localparam int unsigned WDG_W      = 6;
  localparam int unsigned ADDR_W     = 4;
  // register indices of the plain register port
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_SERVICE = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_MASK    = 4'h3;
  localparam logic [3:0] ADDR_CTRL    = 4'h4;
  // option register fields
  localparam int unsigned BIT_RATE  = 0;
  localparam int unsigned BIT_MSTOP = 1;
  localparam int unsigned BIT_LRSTD = 2;
  localparam int unsigned BIT_LPWRD = 3;
  localparam int unsigned BIT_LMODE = 4;
  localparam int unsigned BIT_SHORT_STOP_RECOVERY = 5;
  localparam logic [7:0] CONFIG_MASK = 8'h3f;
  // status / mask fields
  localparam int unsigned ST_WDG  = 0;
  localparam int unsigned ST_LVR  = 1;
  localparam int unsigned ST_STOP = 2;
  localparam int unsigned ST_W    = 3;
  // control register fields
  localparam int unsigned CT_STOP = 0;
  // prescaler stages 12..5 are bits 11..4
  localparam logic [11:0] PRE_KEEP_LOW = 12'h00f;
  localparam logic [5:0]  WDG_FAST_TOP = 6'h01;
  localparam logic [5:0]  WDG_SLOW_TOP = 6'h3f;
  // times in oscillator cycles
  localparam int unsigned RST_PULSE_CYC = 32;
  localparam int unsigned POR_DELAY_CYC = 4096;
  localparam int unsigned REC_SHORT_CYC = 32;
  localparam int unsigned REC_LONG_CYC  = 4096;
  localparam int unsigned CNT_W         = 13;
  typedef enum logic [1:0] {PW_RUN, PW_STOP, PW_RECOVER} wdg_pwr_e;
endpackage : wdg_pkg

//--- wdg_pulse.sv
// wdg_pulse: fixed-length low-active reset pin pulse generator
// assumes trigger is a one-cycle pulse in the ref_clk domain
module wdg_pulse #(
  parameter int unsigned LEN = wdg_pkg::RST_PULSE_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic trigger,
  output logic      pinLow
);
  import wdg_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             active;
  } wdg_pls_s;
  wdg_pls_s state_r, state_nxt;

  // count down while the pin is held low; retrigger restarts the full length
  always_comb begin
    state_nxt = state_r;
    if (trigger) begin
      state_nxt.active = 1'b1;
      state_nxt.cnt    = CNT_W'(LEN - 1);
    end else if (state_r.active) begin
      if (state_r.cnt == '0) begin
        state_nxt.active = 1'b0;
      end else begin
        state_nxt.cnt = state_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pinLow = state_r.active; // [R5]
endmodule : wdg_pulse

//--- wdg_top.sv
// wdg_top: watchdog, prescaler, system option bits and stop recovery
// assumes a plain register port and that ref_clk is the oscillator clock
module wdg_top #(
  parameter logic [7:0]  VECTOR_LOW = 8'h00,  // arbitrary default, strapped per product
  parameter int unsigned POR_DELAY  = wdg_pkg::POR_DELAY_CYC,
  parameter int unsigned REC_LONG   = wdg_pkg::REC_LONG_CYC
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // register port
  input  wire logic [wdg_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [7:0]                regRdata,
  // system side
  input  wire logic                      stopExec,
  input  wire logic                      wakeEvent,
  input  wire logic                      monitorMode,
  input  wire logic                      breakState,
  input  wire logic                      rstPinTest,
  input  wire logic                      irqPinTest,
  input  wire logic                      lvTrip,
  // outputs
  output logic                           systemReset,
  output logic                           rstPinLow,
  output logic                           stopped,
  output logic                           lvMonitorOn,
  output logic                           lvMode5v,
  output logic                           lvResetEn,
  output logic                           irq
);
  import wdg_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [WDG_W-1:0] wdg;
    logic [7:0]       cfg;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;
    logic [CNT_W-1:0] delay;
    logic             porDone;
    logic             longRec;
    logic             sysRst;
    logic [7:0]       rdata;
    wdg_pwr_e         pwr;
  } wdg_state_s;

  wdg_state_s state_r, state_nxt;
  logic       carry;
  logic       wdgDisable;
  logic       wdgOver;
  logic       lvReset;
  logic       pulseLow;
  logic       cfgWr;
  logic       svcWr;
  logic       stsWr;
  logic       mskWr;
  logic       ctlWr;

  // write decode
  assign cfgWr = regWr && (regAddr == ADDR_CONFIG);
  assign svcWr = regWr && (regAddr == ADDR_SERVICE);
  assign stsWr = regWr && (regAddr == ADDR_STATUS);
  assign mskWr = regWr && (regAddr == ADDR_MASK);
  assign ctlWr = regWr && (regAddr == ADDR_CTRL);

  // test voltage on reset pin in break, or either pin in monitor mode
  assign wdgDisable = (monitorMode && (rstPinTest || irqPinTest))
                    || (breakState && rstPinTest); // [R6]

  // prescaler carries out of its top stage once per 4096 cycles
  assign carry = &state_r.pre; // [R19]

  // fast rate counts two prescaler wraps less a 16-cycle service margin
  assign wdgOver = state_r.porDone && !wdgDisable && carry
                 && (state_r.cfg[BIT_RATE] ? (state_r.wdg == WDG_FAST_TOP)
                                           : (state_r.wdg == WDG_SLOW_TOP)); // [R1]

  // monitor reset path gated by the disable bit; a monitor that is off cannot trip
  assign lvReset = lvTrip && !state_r.cfg[BIT_LRSTD] && lvMonitorOn; // [R14] [R15]

  // next-state logic for the whole block
  always_comb begin
    state_nxt        = state_r;
    state_nxt.sysRst = 1'b0;
    state_nxt.rdata  = 8'h00;

    // register reads answer one cycle later
    if (regRd) begin
      case (regAddr)
        ADDR_CONFIG:  state_nxt.rdata = state_r.cfg;
        ADDR_SERVICE: state_nxt.rdata = VECTOR_LOW; // [R7]
        ADDR_STATUS:  state_nxt.rdata = 8'(state_r.status);
        ADDR_MASK:    state_nxt.rdata = 8'(state_r.mask);
        ADDR_CTRL:    state_nxt.rdata = {6'h00, state_r.pwr != PW_RUN, 1'b0};
        default:      state_nxt.rdata = 8'h00;
      endcase
    end

    if (cfgWr) begin
      state_nxt.cfg = regWdata & CONFIG_MASK;
    end
    if (mskWr) begin
      state_nxt.mask = regWdata[ST_W-1:0];
    end
    // write one to clear; a same-cycle set below wins
    if (stsWr) begin
      state_nxt.status = state_r.status & ~regWdata[ST_W-1:0];
    end

    // power-on wait: prescaler held until the delay elapses
    if (!state_r.porDone) begin
      state_nxt.pre = '0;
      if (state_r.delay == CNT_W'(POR_DELAY - 1)) begin
        state_nxt.porDone = 1'b1; // [R9]
        state_nxt.delay   = '0;
      end else begin
        state_nxt.delay = state_r.delay + 1'b1;
      end
    end else begin
      // free-running prescaler and watchdog
      state_nxt.pre = state_r.pre + 1'b1; // [R2] [R18]
      if (carry && !wdgDisable) begin
        state_nxt.wdg = state_r.wdg + 1'b1; // [R19]
      end
      if (svcWr) begin
        state_nxt.wdg = '0; // [R4]
        state_nxt.pre = state_r.pre & PRE_KEEP_LOW; // [R4]
      end

      case (state_r.pwr)
        PW_RUN: begin
          if (stopExec || (ctlWr && regWdata[CT_STOP])) begin
            state_nxt.pwr     = PW_STOP;
            state_nxt.pre     = '0; // [R8]
            state_nxt.longRec = 1'b0;
          end
        end
        PW_STOP: begin
          state_nxt.pre = '0;
          state_nxt.wdg = state_r.wdg;
          if (wakeEvent) begin
            state_nxt.pwr   = PW_RECOVER;
            state_nxt.delay = '0;
          end
        end
        PW_RECOVER: begin
          // short recovery only when the bit is set and no reset intervened
          state_nxt.delay = state_r.delay + 1'b1;
          if (state_r.longRec || !state_r.cfg[BIT_SHORT_STOP_RECOVERY]) begin
            if (state_r.delay == CNT_W'(REC_LONG - 1)) begin
              state_nxt.pwr = PW_RUN; // [R11] [R12]
            end
          end else if (state_r.delay == CNT_W'(REC_SHORT_CYC - 1)) begin
            state_nxt.pwr = PW_RUN; // [R11]
          end
          if (state_nxt.pwr == PW_RUN) begin
            state_nxt.delay = '0;
            state_nxt.status[ST_STOP] = 1'b1;
          end
        end
        default: state_nxt.pwr = PW_RUN;
      endcase

      // internal reset from overflow or the monitor
      if (wdgOver || lvReset) begin
        state_nxt.sysRst = 1'b1; // [R3]
        state_nxt.pre    = '0; // [R10]
        state_nxt.wdg    = '0; // [R10]
        state_nxt.cfg    = state_r.cfg & (8'h01 << BIT_LMODE); // [R16]
        state_nxt.cfg[BIT_RATE]  = 1'b0; // [R1]
        state_nxt.cfg[BIT_MSTOP] = 1'b0; // [R13]
        if (state_r.pwr != PW_RUN) begin
          state_nxt.pwr     = PW_RECOVER; // [R12]
          state_nxt.longRec = 1'b1;
          state_nxt.delay   = '0;
        end
        if (wdgOver) begin
          state_nxt.status[ST_WDG] = 1'b1; // [R5]
        end
        if (lvReset) begin
          state_nxt.status[ST_LVR] = 1'b1;
        end
      end
    end
  end

  // async reset stands for power-on: every option bit cleared
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r     <= '0;
      state_r.pwr <= PW_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // reset pin pulse after a watchdog overflow
  wdg_pulse #(
    .LEN (RST_PULSE_CYC)
  ) u_pulse (
    .ref_clk (ref_clk),
    .rst     (rst),
    .trigger (wdgOver),
    .pinLow  (pulseLow)
  );

  // outputs
  assign regRdata    = state_r.rdata;
  assign systemReset = state_r.sysRst; // [R3]
  assign rstPinLow   = pulseLow; // [R5]
  assign stopped     = state_r.pwr != PW_RUN;
  // monitor powered unless disabled; in stop only with monitor-in-stop set
  assign lvMonitorOn = !state_r.cfg[BIT_LPWRD]
                     && (state_r.pwr == PW_RUN || state_r.cfg[BIT_MSTOP]); // [R13] [R15]
  assign lvMode5v    = state_r.cfg[BIT_LMODE]; // [R16]
  assign lvResetEn   = !state_r.cfg[BIT_LRSTD]; // [R14]
  assign irq         = |(state_r.status & state_r.mask);
endmodule : wdg_top

//--- wdg_top_asserts.sv
// wdg_top_asserts: port-level checks of the watchdog and option block
// assumes ref_clk is the only clock and rst the only reset of wdg_top
module wdg_top_asserts #(
  parameter logic [7:0] VECTOR_LOW = 8'h00
) (
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        rst,
  // register port
  input wire logic [wdg_pkg::ADDR_W-1:0] regAddr,
  input wire logic                        regRd,
  input wire logic [7:0]                  regRdata,
  // system side
  input wire logic                        stopExec,
  input wire logic                        systemReset,
  input wire logic                        rstPinLow,
  input wire logic                        stopped,
  input wire logic                        lvMode5v,
  input wire logic                        lvResetEn
);
  import wdg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [5:0] pinCnt_r;
  // length of the current reset pin pulse, saturation not needed below 64
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) pinCnt_r <= 6'h00;
    else pinCnt_r <= rstPinLow ? pinCnt_r + 6'h01 : 6'h00;
  end
  sequence cfg_rd;
    $past(regRd) && ($past(regAddr) == ADDR_CONFIG);
  endsequence
  sys_pulse_a: assert property (systemReset |=> !systemReset)
    else $error("system reset pulse too long");
  pin_start_a: assert property ($rose(rstPinLow) |-> systemReset)
    else $error("reset pin driven without reset");
  pin_len_a: assert property ($fell(rstPinLow) |-> pinCnt_r == 6'h20)
    else $error("reset pin pulse length wrong");
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside read slot");
  rd_vec_a: assert property ($past(regRd) && $past(regAddr) == ADDR_SERVICE |->
    regRdata == VECTOR_LOW) else $error("service read wrong");
  cfg_hi_a: assert property (cfg_rd |-> regRdata[7:6] == 2'b00)
    else $error("unused option bits read set");
  lv_rst_en_a: assert property (cfg_rd |-> lvResetEn == !regRdata[BIT_LRSTD])
    else $error("monitor reset enable wrong");
  lv_mode_a: assert property (cfg_rd |-> lvMode5v == regRdata[BIT_LMODE])
    else $error("monitor mode wrong");
  stop_enter_a: assert property (stopExec && !systemReset |=> stopped)
    else $error("stop not entered");
  cover property ($rose(rstPinLow));
  cover property ($fell(stopped));
  cover property (cfg_rd);
endmodule : wdg_top_asserts

bind wdg_top wdg_top_asserts #(.VECTOR_LOW(VECTOR_LOW)) i_chk (.ref_clk, .rst, .regAddr,
  .regRd, .regRdata, .stopExec, .systemReset, .rstPinLow, .stopped, .lvMode5v, .lvResetEn);

//--- wdg_top_tb.sv
// wdg_top_tb: self-checking bench for the watchdog and option block
// assumes wdg_top_asserts is compiled alongside and binds itself
module wdg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wdg_pkg::*;
  typedef struct packed {logic [7:0] w; logic [7:0] r; logic [7:0] o;} wdg_row_s;
  localparam logic [7:0] VEC = 8'h5a;  // arbitrary vector byte
  // o = {monitor on, 5 V mode, monitor reset enable}
  wdg_row_s rows [4] = '{'{8'hff, 8'h3f, 8'h02}, '{8'h15, 8'h15, 8'h06},
                         '{8'h2a, 8'h2a, 8'h01}, '{8'h00, 8'h00, 8'h05}};
  logic       ref_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, v;
  logic       stopExec = 1'b0, wakeEvent = 1'b0, monitorMode = 1'b0, rstPinTest = 1'b0;
  logic       breakState = 1'b0, irqPinTest = 1'b0, lvTrip = 1'b0;
  logic       systemReset, rstPinLow, stopped, lvMonitorOn, lvMode5v, lvResetEn, irq;
  int         fails = 0, samples_checked = 0, nRst = 0, c, p;
  // short power-on and long-recovery counts keep the run short
  wdg_top #(.VECTOR_LOW(VEC), .POR_DELAY(16), .REC_LONG(64)) i_dut (.ref_clk, .rst,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .stopExec, .wakeEvent, .monitorMode,
    .breakState, .rstPinTest, .irqPinTest, .lvTrip, .systemReset,
    .rstPinLow, .stopped, .lvMonitorOn, .lvMode5v, .lvResetEn, .irq);
  always #5 ref_clk = ~ref_clk;
  // count reset requests so quiet stretches can be checked afterwards
  always @(posedge ref_clk) if (systemReset === 1'b1) nRst++;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic complete_run();
    $display("counts: %0d checked, %0d failed", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(4'hf, v); chk(v, 8'h00);
    rd(ADDR_CONFIG, v); chk(v, 8'h00);
    chk({6'h00, lvMonitorOn, lvResetEn}, 8'h03);
    rd(ADDR_SERVICE, v); chk(v, VEC);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(ADDR_CONFIG, rows[i].w);
      rd(ADDR_CONFIG, v); chk(v, rows[i].r);
      chk({5'h00, lvMonitorOn, lvMode5v, lvResetEn}, rows[i].o);
    end
    $display("test table done");
    // fast rate, serviced three times well inside the period
    wr(ADDR_CONFIG, 8'h11); wr(ADDR_MASK, 8'h01);
    repeat (3) begin repeat (6000) @(posedge ref_clk); wr(ADDR_SERVICE, 8'ha5); end
    chk(nRst[7:0], 8'h00);
    c = 0;
    while (systemReset !== 1'b1 && c < 9000) begin tick(); c++; end
    if (c == 9000) begin fails++; complete_run(); end
    chk({7'h00, c >= 8170 && c <= 8200}, 8'h01);
    p = 0;
    while (rstPinLow === 1'b1 && p < 40) begin tick(); p++; end
    chk(p[7:0], 8'h20);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_STATUS, v); chk(v, 8'h01);
    rd(ADDR_CONFIG, v); chk(v, 8'h10);
    wr(ADDR_MASK, 8'h00); chk({7'h00, irq}, 8'h00);
    wr(ADDR_MASK, 8'h01); chk({7'h00, irq}, 8'h01);
    wr(ADDR_STATUS, 8'h01); chk({7'h00, irq}, 8'h00);
    $display("test watchdog done");
    // each test-level combination holds a fast-rate watchdog off for over a period
    wr(ADDR_CONFIG, 8'h01);
    nRst = 0;
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_SERVICE, 8'h00);
      @(posedge ref_clk);
      monitorMode <= (k != 2);
      breakState  <= (k == 2);
      rstPinTest  <= (k != 1);
      irqPinTest  <= (k == 1);
      repeat (9000) @(posedge ref_clk);
      monitorMode <= 1'b0;
      breakState  <= 1'b0;
      rstPinTest  <= 1'b0;
      irqPinTest  <= 1'b0;
    end
    chk(nRst[7:0], 8'h00);
    $display("test disable done");
    // short then long recovery from stop
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_SERVICE, 8'h00); wr(ADDR_CONFIG, k ? 8'h00 : 8'h20);
      @(posedge ref_clk); stopExec <= 1'b1;
      @(posedge ref_clk); stopExec <= 1'b0;
      #1 chk({7'h00, stopped}, 8'h01);
      @(posedge ref_clk); wakeEvent <= 1'b1;
      @(posedge ref_clk); wakeEvent <= 1'b0;
      c = 0;
      while (stopped === 1'b1 && c < 5000) begin tick(); c++; end
      chk({7'h00, c >= (k ? 63 : 31) && c <= (k ? 66 : 34)}, 8'h01);
    end
    rd(ADDR_STATUS, v); chk(v, 8'h04);
    wr(ADDR_STATUS, 8'h04);
    $display("test stop done");
    // monitor trips blocked by the reset-disable bit, then by the power-disable bit
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CONFIG, k ? 8'h08 : 8'h04);
      nRst = 0;
      @(posedge ref_clk); lvTrip <= 1'b1;
      @(posedge ref_clk); lvTrip <= 1'b0;
      repeat (2) tick();
      chk(nRst[7:0], 8'h00);
    end
    // a monitor reset while stopped forces the long recovery despite the short bit
    wr(ADDR_CONFIG, 8'h22);
    @(posedge ref_clk); stopExec <= 1'b1;
    @(posedge ref_clk); stopExec <= 1'b0;
    @(posedge ref_clk); lvTrip <= 1'b1;
    @(posedge ref_clk); lvTrip <= 1'b0;
    #1 chk({7'h00, systemReset}, 8'h01);
    c = 0;
    while (stopped === 1'b1 && c < 5000) begin tick(); c++; end
    chk({7'h00, c >= 63 && c <= 66}, 8'h01);
    rd(ADDR_STATUS, v); chk(v, 8'h06);
    $display("test monitor done");
    // power-on reset in mid-run clears the mode bit that other resets keep
    wr(ADDR_CONFIG, 8'h10); chk({7'h00, lvMode5v}, 8'h01);
    @(posedge ref_clk); rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_CONFIG, v); chk(v, 8'h00);
    chk({6'h00, lvMode5v, stopped}, 8'h00);
    $display("test power-on done");
    complete_run();
  end
endmodule : wdg_top_tb
